// ===== fswp_core.sv
// What this block does
// - Keeps 24-bit status word with fixed fields
// - Busy flag high during program, erase, write
// - Cleared write latch refuses all modifying commands
// - Protect select kept non-volatile across power-up
// - Only status write changes protect select
// - Program and erase refused inside protected region
// - Protect select frozen in hardware-protected mode
// - Whole erase only with low select zero
// - Normal decode, bit4 clear: lower/upper large regions protected
// - Inverted, bit4 set: all but small end
// - Write latch set, cleared by listed commands
// - Protect invert ships cleared, non-volatile
// - Normal decode complements the inverted decode
// - Guard 01 with pin low locks word
`timescale 1ns/1ps
`include "fswp_defines.svh"
module fswp_core (
  // Clock, reset, enable
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic i_clk_en,
  input wire logic i_nv_init,
  // Command link
  input wire logic i_link_clk,
  input wire logic i_link_srst,
  input wire logic i_cmd_valid,
  input wire fswp_pkg::fswp_cmd_t i_cmd,
  output logic o_cmd_ready,
  // Protect pin
  input wire logic i_write_protect_pin_n,
  // Status and array control
  output fswp_pkg::fswp_status_t o_status,
  output logic o_op_start,
  output fswp_pkg::fswp_cmd_t o_op,
  output logic o_reject
);
  import fswp_pkg::*;

  localparam logic [12:0] C_SRW = 13'(`FSWP_CYC(`FSWP_T_SRW_NS) - 1);
  localparam logic [12:0] C_PAGE = 13'(`FSWP_CYC(`FSWP_T_PAGE_NS) - 1);
  localparam logic [12:0] C_SECT = 13'(`FSWP_CYC(`FSWP_T_SECT_NS) - 1);
  localparam logic [12:0] C_BLK32 = 13'(`FSWP_CYC(`FSWP_T_BLK32_NS) - 1);
  localparam logic [12:0] C_BLK64 = 13'(`FSWP_CYC(`FSWP_T_BLK64_NS) - 1);
  localparam logic [12:0] C_WHOLE = 13'(`FSWP_CYC(`FSWP_T_WHOLE_NS) - 1);

  fswp_core_st_t st, st_next;
  logic cmd_v;
  fswp_cmd_t cmd;
  logic hw_prot;
  logic word_lock;
  logic modifying;
  logic [23:0] span;
  logic [23:0] lo_addr;
  logic [23:0] hi_addr;
  logic range_prot;
  logic array_ok;
  logic [12:0] dur;
  logic [23:0] merged;
  logic [23:0] byte_mask;

  fswp_link_cdc u_cdc (
    .i_link_clk(i_link_clk),
    .i_link_srst(i_link_srst),
    .i_cmd_valid(i_cmd_valid),
    .i_cmd(i_cmd),
    .o_cmd_ready(o_cmd_ready),
    .i_ref_clk(i_ref_clk),
    .i_srst(i_srst),
    .i_clk_en(i_clk_en),
    .o_cmd_valid(cmd_v),
    .o_cmd(cmd)
  );

  // Regions are aligned and touch an array end, so checking both ends of a span suffices
  function automatic logic addr_prot(input logic [4:0] sel, input logic inv, input logic [23:0] a);
    logic [2:0] low;
    logic [4:0] sh;
    logic [23:0] size;
    logic base;
    low = sel[2:0];
    sh = 5'd0;
    size = 24'h000000;
    base = 1'b0;
    if (low == 3'h7) begin
      base = 1'b1;
    end else if (low != 3'h0) begin
      if (sel[4]) begin
        sh = (low > 3'h3) ? 5'(`FSWP_SH_SMALL_MAX) : 5'(`FSWP_SH_SMALL_BASE + low);
      end else begin
        sh = 5'(`FSWP_SH_LARGE_BASE + low);
      end
      size = 24'h000001 << sh;
      base = sel[3] ? (a < size) : (a >= (`FSWP_ARRAY_TOP - size));
    end
    return base ^ inv;
  endfunction

  always_comb begin
    span = `FSWP_PAGE_MASK;
    dur = C_PAGE;
    case (cmd.op)
      OP_SECTOR_ERASE: begin
        span = `FSWP_SECT_MASK;
        dur = C_SECT;
      end
      OP_BLOCK32_ERASE: begin
        span = `FSWP_BLK32_MASK;
        dur = C_BLK32;
      end
      OP_BLOCK64_ERASE: begin
        span = `FSWP_BLK64_MASK;
        dur = C_BLK64;
      end
      OP_WHOLE_ERASE: dur = C_WHOLE;
      default: ;
    endcase
  end

  assign lo_addr = {1'b0, cmd.addr[22:0]} & ~span;
  assign hi_addr = lo_addr | span;
  assign range_prot = addr_prot(st.sr.protect_select, st.sr.protect_invert, lo_addr) ||
                      addr_prot(st.sr.protect_select, st.sr.protect_invert, hi_addr);
  assign array_ok = (cmd.op == OP_WHOLE_ERASE) ?
                    (st.sr.protect_select[2:0] == 3'h0 && !st.sr.protect_invert) : !range_prot;
  assign hw_prot = !st.sr.status_guard_bit1 && st.sr.status_guard_bit0 && !st.wp_lvl;
  // Guard bit1 set means lock-down; power-up releases it only while guard bit0 is clear
  assign word_lock = hw_prot || st.sr.status_guard_bit1;
  assign modifying = cmd.op inside {OP_STATUS_WRITE, OP_PAGE_WRITE, OP_SECTOR_ERASE,
                                    OP_BLOCK32_ERASE, OP_BLOCK64_ERASE, OP_WHOLE_ERASE};
  assign byte_mask = `FSWP_NV_MASK & (24'h0000ff << {cmd.byte_idx, 3'h0});
  always_comb begin
    merged = (st.sr & ~byte_mask) | (({16'h0000, cmd.data} << {cmd.byte_idx, 3'h0}) & byte_mask);
    // Security locks are one-time: a written 0 never clears a 1
    merged[13:11] = merged[13:11] | st.sr.security_lock;
  end

  always_comb begin
    st_next = st;
    st_next.op_start = 1'b0;
    st_next.reject = 1'b0;
    st_next.wp_s = {st.wp_s[1:0], i_write_protect_pin_n};
    if (st.wp_s[2] == st.wp_s[1]) begin
      st_next.wp_lvl = st.wp_s[2];
    end
    case (st.fsm)
      ST_IDLE: begin
        if (cmd_v) begin
          case (cmd.op)
            OP_WRITE_ENABLE: st_next.sr.write_latch_flag = 1'b1;
            OP_WRITE_DISABLE: st_next.sr.write_latch_flag = 1'b0;
            OP_STATUS_WRITE: begin
              st_next.sr.write_latch_flag = 1'b0;
              if (st.sr.write_latch_flag && !word_lock) begin
                st_next.pend = merged;
                st_next.pend_v = 1'b1;
                st_next.cnt = C_SRW;
                st_next.fsm = ST_BUSY;
                st_next.sr.busy_flag = 1'b1;
              end else begin
                st_next.reject = 1'b1;
              end
            end
            OP_PAGE_WRITE, OP_SECTOR_ERASE, OP_BLOCK32_ERASE, OP_BLOCK64_ERASE, OP_WHOLE_ERASE: begin
              st_next.sr.write_latch_flag = 1'b0;
              if (st.sr.write_latch_flag && array_ok) begin
                st_next.op_start = 1'b1;
                st_next.op = cmd;
                st_next.op.addr = lo_addr;
                st_next.cnt = dur;
                st_next.fsm = ST_BUSY;
                st_next.sr.busy_flag = 1'b1;
              end else begin
                st_next.reject = 1'b1;
              end
            end
            default: ;
          endcase
        end
      end
      ST_BUSY: begin
        // Nothing is queued while busy; modifying commands are refused outright
        if (cmd_v && modifying) begin
          st_next.reject = 1'b1;
        end
        if (st.cnt == 13'h0000) begin
          st_next.fsm = ST_IDLE;
          if (st.pend_v) begin
            st_next.sr = fswp_status_t'((st.sr & ~`FSWP_NV_MASK) | (st.pend & `FSWP_NV_MASK));
            st_next.pend_v = 1'b0;
          end
          st_next.sr.busy_flag = 1'b0;
        end else begin
          st_next.cnt = st.cnt - 13'h0001;
        end
      end
      default: st_next.fsm = ST_IDLE;
    endcase
    if (i_srst) begin
      // Power-up keeps the non-volatile bits, except guard bit1 under guard 10, presets the pin sync high and drops everything else
      st_next = '0;
      st_next.sr = fswp_status_t'(st.sr & `FSWP_NV_MASK);
      st_next.wp_s = 3'h7;
      st_next.wp_lvl = 1'b1;
      if (st.sr.status_guard_bit1 && !st.sr.status_guard_bit0) begin
        st_next.sr.status_guard_bit1 = 1'b0;
      end
    end
    if (i_nv_init) begin
      st_next.sr = fswp_status_t'(`FSWP_NV_DEFAULT);
      st_next.fsm = ST_IDLE;
      st_next.pend_v = 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst || i_clk_en) begin
      st <= st_next;
    end
  end

  assign o_status = st.sr;
  assign o_op_start = st.op_start;
  assign o_op = st.op;
  assign o_reject = st.reject;

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_srst || i_nv_init);

  sequence s_take;
    i_clk_en && st.fsm == ST_IDLE && cmd_v;
  endsequence
  sequence s_busy_hold;
    st.sr.busy_flag [*2];
  endsequence
  sequence s_no_start;
    !o_op_start && !st.sr.busy_flag;
  endsequence

  a_busy_starts: assert property (o_op_start |-> s_busy_hold)
    else $error("busy not held after operation start");
  a_busy_ends: assert property (i_clk_en && st.fsm == ST_BUSY && st.cnt == 13'h0000 |=> !st.sr.busy_flag)
    else $error("busy still set after operation end");
  a_latch_refuse: assert property (s_take ##0 (modifying && !st.sr.write_latch_flag) |=> s_no_start)
    else $error("command executed with write latch clear");
  a_latch_set: assert property (s_take ##0 cmd.op == OP_WRITE_ENABLE |=> st.sr.write_latch_flag)
    else $error("write latch not set by enable");
  a_latch_clear: assert property (s_take ##0 (modifying || cmd.op == OP_WRITE_DISABLE) |=> !st.sr.write_latch_flag)
    else $error("write latch not cleared");
  a_select_stable: assert property (i_clk_en && !(st.fsm == ST_BUSY && st.cnt == 13'h0000 && st.pend_v)
                                    |=> $stable(st.sr.protect_select))
    else $error("protect select changed outside status write");
  a_region_refuse: assert property (s_take ##0 (cmd.op inside {OP_PAGE_WRITE, OP_SECTOR_ERASE, OP_BLOCK32_ERASE,
                                    OP_BLOCK64_ERASE} && range_prot) |=> s_no_start ##0 o_reject)
    else $error("protected region program or erase executed");
  a_whole_refuse: assert property (s_take ##0 (cmd.op == OP_WHOLE_ERASE &&
                                   (st.sr.protect_select[2:0] != 3'h0 || st.sr.protect_invert)) |=> s_no_start)
    else $error("whole erase executed while protected");
  a_hw_lock: assert property (s_take ##0 (cmd.op == OP_STATUS_WRITE && hw_prot) |=> !st.sr.busy_flag ##1
                              $stable(st.sr.protect_select))
    else $error("status word written in hardware-protected mode");
  a_reject_idle: assert property (o_reject && $past(st.fsm) == ST_IDLE |-> !st.sr.busy_flag && !o_op_start)
    else $error("refused command set busy");
endmodule

// ===== fswp_defines.svh
`ifndef FSWP_DEFINES_SVH
`define FSWP_DEFINES_SVH

// Reference clock period and operation times
`define FSWP_CLK_NS 10
`define FSWP_T_SRW_NS 1000
`define FSWP_T_PAGE_NS 2000
`define FSWP_T_SECT_NS 8000
`define FSWP_T_BLK32_NS 16000
`define FSWP_T_BLK64_NS 24000
`define FSWP_T_WHOLE_NS 40000
`define FSWP_CYC(ns) (((ns) + `FSWP_CLK_NS - 1) / `FSWP_CLK_NS)

// Array geometry
`define FSWP_ARRAY_TOP 24'h800000
`define FSWP_PAGE_MASK 24'h0000ff
`define FSWP_SECT_MASK 24'h000fff
`define FSWP_BLK32_MASK 24'h007fff
`define FSWP_BLK64_MASK 24'h00ffff

// Region size shifts
`define FSWP_SH_LARGE_BASE 16
`define FSWP_SH_SMALL_BASE 11
`define FSWP_SH_SMALL_MAX 15

// Status word: non-volatile and writable bits, factory value
`define FSWP_NV_MASK 24'h607bfc
`define FSWP_NV_DEFAULT 24'h200000

`endif

// ===== fswp_pkg.sv
package fswp_pkg;

  typedef enum logic [3:0] {
    OP_NONE,
    OP_WRITE_ENABLE,
    OP_WRITE_DISABLE,
    OP_STATUS_WRITE,
    OP_PAGE_WRITE,
    OP_SECTOR_ERASE,
    OP_BLOCK32_ERASE,
    OP_BLOCK64_ERASE,
    OP_WHOLE_ERASE
  } fswp_op_t;

  typedef struct packed {
    fswp_op_t op;
    logic [23:0] addr;
    logic [1:0] byte_idx;
    logic [7:0] data;
  } fswp_cmd_t;

  typedef struct packed {
    logic rsvd23;
    logic drive_strength_hi;
    logic drive_strength_lo;
    logic perf_mode_flag;
    logic [3:0] rsvd19_16;
    logic erase_suspended_flag;
    logic protect_invert;
    logic [2:0] security_lock;
    logic program_suspended_flag;
    logic four_lane_enable;
    logic status_guard_bit1;
    logic status_guard_bit0;
    logic [4:0] protect_select;
    logic write_latch_flag;
    logic busy_flag;
  } fswp_status_t;

  typedef enum logic {
    ST_IDLE,
    ST_BUSY
  } fswp_state_t;

  typedef struct packed {
    fswp_state_t fsm;
    logic [12:0] cnt;
    fswp_status_t sr;
    logic [23:0] pend;
    logic pend_v;
    logic [2:0] wp_s;
    logic wp_lvl;
    logic op_start;
    logic reject;
    fswp_cmd_t op;
  } fswp_core_st_t;

  typedef struct packed {
    logic req_tgl;
    fswp_cmd_t hold;
    logic ack_s1;
    logic ack_s2;
  } fswp_lnk_st_t;

  typedef struct packed {
    logic req_s1;
    logic req_s2;
    logic req_s3;
    logic ack_tgl;
    logic cmd_v;
    fswp_cmd_t cmd;
  } fswp_ref_st_t;

endpackage

// ===== fswp_link_cdc.sv
`timescale 1ns/1ps
`include "fswp_defines.svh"
module fswp_link_cdc (
  // Link side
  input wire logic i_link_clk,
  input wire logic i_link_srst,
  input wire logic i_cmd_valid,
  input wire fswp_pkg::fswp_cmd_t i_cmd,
  output logic o_cmd_ready,
  // Reference side
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic i_clk_en,
  output logic o_cmd_valid,
  output fswp_pkg::fswp_cmd_t o_cmd
);
  import fswp_pkg::*;

  fswp_lnk_st_t ls, ls_next;
  fswp_ref_st_t rs, rs_next;

  // Hold word stays put until the ack toggle returns
  assign o_cmd_ready = (ls.req_tgl == ls.ack_s2);

  always_comb begin
    ls_next = ls;
    ls_next.ack_s1 = rs.ack_tgl;
    ls_next.ack_s2 = ls.ack_s1;
    if (i_cmd_valid && o_cmd_ready) begin
      ls_next.hold = i_cmd;
      ls_next.req_tgl = ~ls.req_tgl;
    end
    if (i_link_srst) begin
      ls_next = '0;
    end
  end

  always_ff @(posedge i_link_clk) begin
    ls <= ls_next;
  end

  always_comb begin
    rs_next = rs;
    rs_next.req_s1 = ls.req_tgl;
    rs_next.req_s2 = rs.req_s1;
    rs_next.req_s3 = rs.req_s2;
    rs_next.cmd_v = (rs.req_s2 != rs.req_s3);
    if (rs.req_s2 != rs.req_s3) begin
      rs_next.cmd = ls.hold;
      rs_next.ack_tgl = ~rs.ack_tgl;
    end
    if (i_srst) begin
      // Toggle history keeps running; clearing it would replay the last held command
      rs_next.ack_tgl = rs.req_s2;
      rs_next.cmd_v = 1'b0;
      rs_next.cmd = '0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst || i_clk_en) begin
      rs <= rs_next;
    end
  end

  assign o_cmd_valid = rs.cmd_v;
  assign o_cmd = rs.cmd;
endmodule

// ===== fswp_host_model.sv
`timescale 1ns/1ps
module fswp_host_model (
  // Link side
  input wire logic i_link_clk,
  input wire logic i_cmd_ready,
  output logic o_cmd_valid,
  output fswp_pkg::fswp_cmd_t o_cmd
);
  import fswp_pkg::*;

  int stalls = 0;

  initial begin
    o_cmd_valid = 1'b0;
    o_cmd = '0;
  end

  // Offer only when free, held until the taking rising edge
  task automatic send(input fswp_cmd_t c);
    int n;
    n = 0;
    @(negedge i_link_clk);
    while (i_cmd_ready !== 1'b1 && n < 200) begin
      @(negedge i_link_clk);
      n++;
    end
    if (n == 200) begin
      stalls++;
      $display("[ERR] link ready expected 1 seen 0");
    end
    o_cmd_valid = 1'b1;
    o_cmd = c;
    @(posedge i_link_clk);
    @(negedge i_link_clk);
    o_cmd_valid = 1'b0;
    // Released lines show the inverse, never a stale copy
    o_cmd = fswp_cmd_t'(~c);
  endtask
endmodule

// ===== test_flash_status_write_protection.sv
`timescale 1ns/1ps
module test_flash_status_write_protection;
  import fswp_pkg::*;
  logic i_ref_clk = 1'b0;
  logic i_link_clk = 1'b0;
  logic i_srst = 1'b1;
  logic i_link_srst = 1'b1;
  logic i_nv_init = 1'b1;
  logic wp_pin_n = 1'b1;
  logic clk_en = 1'b1;
  logic cmd_valid, cmd_ready, op_start, reject;
  fswp_cmd_t cmd, op;
  fswp_status_t status;
  logic [23:0] sr_m;
  int mismatches = 0;
  int tests_run = 0;
  int seed = 23739;
  int span [9] = '{0, 0, 0, 0, 256, 4096, 32768, 65536, 256};
  int dur [9] = '{0, 0, 0, 100, 200, 800, 1600, 2400, 4000};

  always #5 i_ref_clk = ~i_ref_clk;
  initial #3 forever #24 i_link_clk = ~i_link_clk;

  fswp_core dut (
    .i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_clk_en(clk_en), .i_nv_init(i_nv_init),
    .i_link_clk(i_link_clk), .i_link_srst(i_link_srst), .i_cmd_valid(cmd_valid), .i_cmd(cmd),
    .o_cmd_ready(cmd_ready), .i_write_protect_pin_n(wp_pin_n), .o_status(status),
    .o_op_start(op_start), .o_op(op), .o_reject(reject)
  );
  fswp_host_model host (.i_link_clk(i_link_clk), .i_cmd_ready(cmd_ready), .o_cmd_valid(cmd_valid), .o_cmd(cmd));

  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_sr(input logic [23:0] exp);
    tests_run++;
    if (status !== exp) begin
      mismatches++;
      $display("[ERR] status expected %h seen %h", exp, status);
    end
  endtask

  // Shielded span is one interval; inverted mode shields its complement
  function automatic bit prot(input logic [4:0] s, input logic c, input int lo, input int hi);
    int a, b, z, k;
    k = s[2:0];
    z = s[4] ? 4096 << ((k > 4 ? 4 : k) - 1) : 131072 << (k - 1);
    a = k == 0 ? 8388608 : (k == 7 || s[3]) ? 0 : 8388608 - z;
    b = (s[3] && k != 0 && k != 7) ? z - 1 : 8388607;
    return c ? !(lo >= a && hi <= b) : !(hi < a || lo > b);
  endfunction

  task automatic run(input fswp_op_t o, input logic [23:0] ad, input logic [1:0] bi, input logic [7:0] d);
    int lo, n;
    logic md, rej;
    logic [23:0] m;
    lo = ad & ~(span[o] - 1);
    md = o >= OP_STATUS_WRITE;
    rej = md && (!sr_m[1] || (o == OP_STATUS_WRITE ? sr_m[8] || (sr_m[7] && !wp_pin_n) :
      o == OP_WHOLE_ERASE ? sr_m[4:2] != 3'h0 || sr_m[14] : prot(sr_m[6:2], sr_m[14], lo, lo + span[o] - 1)));
    sr_m[1] = o == OP_WRITE_ENABLE;
    m = 24'h607bfc & (24'hff << (8 * bi));
    if (o == OP_STATUS_WRITE && !rej)
      sr_m = (sr_m & ~m) | (({16'h0, d} << (8 * bi)) & m) | (sr_m & 24'h003800);
    host.send(fswp_cmd_t'{o, ad, bi, d});
    n = 0;
    while (!(op_start === 1'b1 || reject === 1'b1 || status.busy_flag === 1'b1) && n < (md ? 80 : 12)) begin
      @(negedge i_ref_clk);
      n++;
    end
    chk("reject", rej, reject);
    if (o != OP_STATUS_WRITE)
      chk("op start", md && !rej, op_start);
    if (op_start === 1'b1) begin
      chk("op addr", 24'(lo), op.addr);
      chk("op code", 24'(o), 24'(op.op));
    end
    n = 0;
    while (status.busy_flag === 1'b1 && n < 5000) begin
      @(negedge i_ref_clk);
      n++;
    end
    chk("busy cycles", 24'(rej ? 0 : dur[o]), 24'(n));
    @(negedge i_ref_clk);
    chk_sr(sr_m);
  endtask

  task automatic set_prot(input logic [4:0] s, input logic c, input logic g0, input logic [5:0] x);
    run(OP_WRITE_ENABLE, 24'h0, 2'd0, 8'h00);
    run(OP_STATUS_WRITE, 24'h0, 2'd0, {g0, s, 2'b00});
    run(OP_WRITE_ENABLE, 24'h0, 2'd0, 8'h00);
    run(OP_STATUS_WRITE, 24'h0, 2'd1, {1'b0, c, x[5:1], 1'b0});
  endtask

  task automatic summarize;
    mismatches += host.stalls;
    $display("tests_run=%0d mismatches=%0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    #1000000;
    mismatches++;
    $display("[ERR] watchdog expected done seen hang");
    summarize();
  end

  initial begin
    int r;
    fswp_op_t o;
    logic [23:0] a;
    repeat (12) @(negedge i_ref_clk);
    i_srst = 1'b0;
    i_link_srst = 1'b0;
    i_nv_init = 1'b0;
    sr_m = 24'h200000;
    repeat (3) @(negedge i_ref_clk);
    chk_sr(sr_m);
    run(OP_PAGE_WRITE, 24'h000100, 2'd0, 8'h00);
    run(OP_STATUS_WRITE, 24'h0, 2'd0, 8'h1c);
    run(OP_WRITE_ENABLE, 24'h0, 2'd0, 8'h00);
    run(OP_WRITE_DISABLE, 24'h0, 2'd0, 8'h00);
    run(OP_SECTOR_ERASE, 24'h001234, 2'd0, 8'h00);
    $display("test write latch done");
    for (int k = 0; k < 64; k++) begin
      r = $random(seed);
      set_prot(k[4:0], k[5], 1'b0, r[10:5]);
      run(OP_WRITE_ENABLE, 24'h0, 2'd0, 8'h00);
      o = k % 4 == 0 ? OP_WHOLE_ERASE : r[0] ? OP_PAGE_WRITE : OP_SECTOR_ERASE;
      a = r[2] ? {1'b0, r[22:0]} : {r[1] ? 8'h7f : 8'h00, r[31:16]};
      run(o, a, 2'd0, 8'h00);
    end
    $display("test protect decode done");
    run(OP_WRITE_ENABLE, 24'h0, 2'd0, 8'h00);
    run(OP_BLOCK32_ERASE, 24'h123456, 2'd0, 8'h00);
    run(OP_WRITE_ENABLE, 24'h0, 2'd0, 8'h00);
    run(OP_BLOCK64_ERASE, 24'h7f8abc, 2'd0, 8'h00);
    run(OP_WRITE_ENABLE, 24'h0, 2'd0, 8'h00);
    run(OP_STATUS_WRITE, 24'h0, 2'd2, r[7:0]);
    $display("test erase sizes done");
    set_prot(5'h05, 1'b0, 1'b1, 6'h00);
    wp_pin_n = 1'b0;
    repeat (6) @(negedge i_ref_clk);
    run(OP_WRITE_ENABLE, 24'h0, 2'd0, 8'h00);
    run(OP_STATUS_WRITE, 24'h0, 2'd0, 8'h00);
    wp_pin_n = 1'b1;
    repeat (6) @(negedge i_ref_clk);
    set_prot(5'h06, 1'b1, 1'b0, 6'h00);
    $display("test hardware protect done");
    run(OP_WRITE_ENABLE, 24'h0, 2'd0, 8'h00);
    // Link side still takes one command while the core is frozen
    clk_en = 1'b0;
    host.send(fswp_cmd_t'{OP_WRITE_DISABLE, 24'h0, 2'd0, 8'h00});
    repeat (20) @(negedge i_ref_clk);
    chk_sr(sr_m);
    clk_en = 1'b1;
    sr_m[1] = 1'b0;
    repeat (12) @(negedge i_ref_clk);
    chk_sr(sr_m);
    $display("test clock enable done");
    run(OP_WRITE_ENABLE, 24'h0, 2'd0, 8'h00);
    run(OP_STATUS_WRITE, 24'h0, 2'd1, 8'h01);
    run(OP_WRITE_ENABLE, 24'h0, 2'd0, 8'h00);
    run(OP_STATUS_WRITE, 24'h0, 2'd0, 8'h00);
    $display("test lock down done");
    i_srst = 1'b1;
    repeat (3) @(negedge i_ref_clk);
    i_srst = 1'b0;
    sr_m[1:0] = 2'b00;
    sr_m[8] = 1'b0;
    repeat (3) @(negedge i_ref_clk);
    chk_sr(sr_m);
    $display("test reset retain done");
    summarize();
  end
endmodule
